/* File: design/tasr_defines.svh */
// Offsets, field positions, reset values and protocol constants.
// Assumes a 4-bit register port address with 8-bit data.
`ifndef TASR_DEFINES_SVH
`define TASR_DEFINES_SVH
`define TASR_OFF_CONFIG   4'h0
`define TASR_OFF_LOC_TEMP 4'h1
`define TASR_OFF_REM_TEMP 4'h2
`define TASR_OFF_LOC_HLIM 4'h3
`define TASR_OFF_LOC_LLIM 4'h4
`define TASR_OFF_REM_HLIM 4'h5
`define TASR_OFF_REM_LLIM 4'h6
`define TASR_OFF_ONESHOT  4'h7
`define TASR_OFF_STATUS   4'h8
`define TASR_CFG_MASK_BIT 7
`define TASR_CFG_HALT_BIT 6
`define TASR_CFG_RESET    8'h80
`define TASR_HLIM_RESET   8'h7f
`define TASR_LLIM_RESET   8'hc9
`define TASR_ARA_ADDR     7'h0c
`define TASR_BITS_BYTE    4'h8
`endif

/* File: design/tasr_pkg.sv */
// Types shared by the thermal alert block.
// Assumes tasr_defines.svh holds the register and protocol constants; state codes live here.
package tasr_pkg;
	typedef struct packed {
		logic [7:0] loc_hi;
		logic [7:0] loc_lo;
		logic [7:0] rem_hi;
		logic [7:0] rem_lo;
	} tasr_limits_t;
	typedef struct packed {
		logic       scl;
		logic       sda;
	} tasr_wire_t;
	typedef enum logic [6:0] {
		ST_IDLE = 7'h01,
		ST_ADDR = 7'h02,
		ST_AACK = 7'h04,
		ST_WR   = 7'h08,
		ST_WACK = 7'h10,
		ST_RD   = 7'h20,
		ST_RACK = 7'h40
	} tasr_state_t;
endpackage

/* File: design/tasr_top.sv */
// Alert/comparator logic, standby control and serial slave front end.
// Assumes a 20 MHz clock; pins are asynchronous, converter is on-clock.
//
// Operation
// RULE_01: In alert mode, latch alert on any local/remote limit breach or open diode.
// RULE_02: Mask bit at 1 blocks every alert assertion.
// RULE_03: Answer alert response address while alerting; that answer clears and rearms.
// RULE_04: Condition still present after the response re-asserts alert at once.
// RULE_05: Shared output pin is open drain, active low, only pulls low.
// RULE_06: Comparator mode drives output on remote at/above high limit or open diode.
// RULE_07: Comparator output never latches; releases when remote below high limit.
// RULE_08: Mask bit at 1 also suppresses comparator output.
// RULE_09: Function select high means alert, low means comparator; floating is alert.
// RULE_10: Standby pin low forces standby regardless of halt bit or one-shot.
// RULE_11: Standby stops conversions and freezes temperatures; outputs keep working.
// RULE_12: Serial slave and registers work fully during standby.
// RULE_13: Pin high: run if halt 0; halted one-shot does one conversion.
// RULE_14: Two three-level straps decode into one of nine slave addresses.
// RULE_15: Straps sampled only at reset; address then held fixed.
// RULE_16: Device is slave only; host makes every clock and frames transfers.
// RULE_17: Bytes shift most significant bit first.
// RULE_18: Ignore bus until start: data falls while clock high.
// RULE_19: Stop, data rising with clock high, ends every transfer.
// RULE_20: Host changes data only while clock low.
// RULE_21: Receiver acknowledges by holding data low over ninth clock high.
// RULE_22: Match seven address bits before acknowledging; eighth bit 1 read, 0 write.
// RULE_23: Mask is config bit 7, resets to 1.
// RULE_24: Halt is config bit 6, resets to 0.
// RULE_25: Temperatures and limits are signed 8-bit; comparisons are signed.
// RULE_26: Standby pin and function select are synchronised before use.
//
// Design decisions made here: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "tasr_defines.svh"
module tasr_top
(
	// Clock and reset
	input  wire logic       clk_sys_i,
	input  wire logic       reset_n_i,
	// Register port
	input  wire logic [3:0] reg_addr_i,
	input  wire logic [7:0] reg_wdata_i,
	input  wire logic       reg_wr_i,
	input  wire logic       reg_rd_i,
	output logic      [7:0] reg_rdata_o,
	// Converter side
	input  wire logic [7:0] local_temp_i,
	input  wire logic [7:0] remote_temperature_i,
	input  wire logic       remote_open_i,
	input  wire logic       temp_valid_i,
	output logic            conv_active_o,
	// Mode pins
	input  wire logic       standby_pin_n_i,
	input  wire logic       pin_func_sel_i,
	input  wire logic [1:0] addr_strap_hi_i,
	input  wire logic [1:0] addr_strap_lo_i,
	// Serial link
	input  wire tasr_pkg::tasr_wire_t bus_i,
	output logic            serial_data_pin_o,
	output logic            serial_data_pin_oe_n_o,
	// Alert or comparator pin
	output logic            alert_pin_o,
	output logic            alert_pin_oe_n_o
);
	import tasr_pkg::*;

	function automatic logic ge_s(input logic [7:0] a, input logic [7:0] b);
		ge_s = $signed(a) >= $signed(b); // RULE_25
	endfunction

	function automatic logic [6:0] strap_addr(input logic [1:0] lo, input logic [1:0] hi);
		logic [6:0] base;
		base = (lo == 2'h0) ? 7'h18 : (lo == 2'h1) ? 7'h29 : 7'h4c;
		strap_addr = base + ((hi == 2'h0) ? 7'h0 : (hi == 2'h1) ? 7'h1 : 7'h2); // RULE_14
	endfunction

	////////////////////////////////////////////////////////////////////
	// Synchronisers; first stages feed nothing but the second
	logic [2:0] scl_sync_reg, sda_sync_reg;
	logic [1:0] standby_pin_n_sync_reg, sel_sync_reg;
	logic [7:0] strap_sync_reg;
	always_ff @(posedge clk_sys_i)
	begin
		// Straps are pins too; held steady through reset, so two flops cost nothing
		strap_sync_reg <= {strap_sync_reg[3:0], addr_strap_hi_i, addr_strap_lo_i};
		scl_sync_reg  <= {scl_sync_reg[1:0], bus_i.scl};
		sda_sync_reg  <= {sda_sync_reg[1:0], bus_i.sda};
		standby_pin_n_sync_reg <= {standby_pin_n_sync_reg[0], standby_pin_n_i}; // RULE_26
		sel_sync_reg  <= {sel_sync_reg[0], pin_func_sel_i}; // RULE_26
	end
	wire scl_w      = scl_sync_reg[1];
	wire sda_w      = sda_sync_reg[1];
	wire scl_rise_w = scl_w & ~scl_sync_reg[2]; // RULE_16
	wire scl_fall_w = ~scl_w & scl_sync_reg[2];
	wire start_w    = scl_w & scl_sync_reg[2] & ~sda_w & sda_sync_reg[2]; // RULE_18
	wire stop_w     = scl_w & scl_sync_reg[2] & sda_w & ~sda_sync_reg[2]; // RULE_19
	wire standby_pin_n_w     = standby_pin_n_sync_reg[1];
	wire alert_mode_w = sel_sync_reg[1]; // RULE_09

	////////////////////////////////////////////////////////////////////
	// Straps caught on the first edge after reset release
	logic [6:0] slave_addr_reg;
	logic       strap_done_reg;
	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
			strap_done_reg <= 1'b0;
		else
			strap_done_reg <= 1'b1;
		if (reset_n_i && !strap_done_reg)
			slave_addr_reg <= strap_addr(strap_sync_reg[5:4], strap_sync_reg[7:6]); // RULE_15
	end

	////////////////////////////////////////////////////////////////////
	// Register file
	logic [7:0]   cfg_reg, loc_temp_reg, rem_temp_reg;
	tasr_limits_t lim_reg;
	logic         rem_open_reg, oneshot_reg, alert_latch_reg;
	wire mask_w = cfg_reg[`TASR_CFG_MASK_BIT]; // RULE_23
	wire halt_w = cfg_reg[`TASR_CFG_HALT_BIT]; // RULE_24
	wire wr_cfg_w = reg_wr_i && (reg_addr_i == `TASR_OFF_CONFIG);
	wire wr_os_w  = reg_wr_i && (reg_addr_i == `TASR_OFF_ONESHOT);
	wire run_w    = standby_pin_n_w && (!halt_w || oneshot_reg); // RULE_10 RULE_13
	wire capture_w = run_w && temp_valid_i; // RULE_11

	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
		begin
			cfg_reg <= `TASR_CFG_RESET;
			lim_reg <= {`TASR_HLIM_RESET, `TASR_LLIM_RESET, `TASR_HLIM_RESET, `TASR_LLIM_RESET};
		end
		else if (reg_wr_i) // RULE_12
		begin
			if (wr_cfg_w)
				cfg_reg <= reg_wdata_i & 8'hc0;
			if (reg_addr_i == `TASR_OFF_LOC_HLIM)
				lim_reg.loc_hi <= reg_wdata_i;
			if (reg_addr_i == `TASR_OFF_LOC_LLIM)
				lim_reg.loc_lo <= reg_wdata_i;
			if (reg_addr_i == `TASR_OFF_REM_HLIM)
				lim_reg.rem_hi <= reg_wdata_i;
			if (reg_addr_i == `TASR_OFF_REM_LLIM)
				lim_reg.rem_lo <= reg_wdata_i;
		end
	end

	// One-shot only means something while halted; the conversion end clears it
	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
			oneshot_reg <= 1'b0;
		else if (wr_os_w && standby_pin_n_w && halt_w)
			oneshot_reg <= 1'b1; // RULE_13
		else if (temp_valid_i || !standby_pin_n_w || !halt_w)
			oneshot_reg <= 1'b0;
	end

	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
		begin
			loc_temp_reg  <= 8'h00;
			rem_temp_reg  <= 8'h00;
			rem_open_reg  <= 1'b0;
			conv_active_o <= 1'b0;
		end
		else
		begin
			conv_active_o <= run_w && !(temp_valid_i && halt_w);
			if (capture_w) // RULE_11
			begin
				loc_temp_reg <= local_temp_i;
				rem_temp_reg <= remote_temperature_i;
				rem_open_reg <= remote_open_i;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Alarm conditions; compared against held values so standby freezes them too
	wire loc_hi_w  = ge_s(loc_temp_reg, lim_reg.loc_hi);
	wire loc_lo_w  = !ge_s(loc_temp_reg, lim_reg.loc_lo);
	wire rem_hi_w  = ge_s(rem_temp_reg, lim_reg.rem_hi);
	wire rem_lo_w  = !ge_s(rem_temp_reg, lim_reg.rem_lo);
	wire alarm_w   = loc_hi_w | loc_lo_w | rem_hi_w | rem_lo_w | rem_open_reg; // RULE_01
	wire comp_w    = rem_hi_w | rem_open_reg; // RULE_06 RULE_07
	logic ara_done_reg;
	wire alert_set_w = alert_mode_w && !mask_w && alarm_w; // RULE_01 RULE_02

	// Set beats the response clear, so a lasting condition re-fires at once
	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
			alert_latch_reg <= 1'b0;
		else if (alert_set_w)
			alert_latch_reg <= 1'b1; // RULE_04
		else if (ara_done_reg || !alert_mode_w || mask_w)
			alert_latch_reg <= 1'b0; // RULE_03
	end

	wire pin_low_w = !mask_w && (alert_mode_w ? alert_latch_reg : comp_w); // RULE_02 RULE_08
	always_ff @(posedge clk_sys_i)
	begin
		alert_pin_o <= 1'b0; // RULE_05
		if (!reset_n_i)
			alert_pin_oe_n_o <= 1'b1;
		else
			alert_pin_oe_n_o <= !pin_low_w;
	end

	////////////////////////////////////////////////////////////////////
	// Serial slave, clock only ever from the host
	tasr_state_t state_reg;
	logic [3:0]  bit_cnt_reg;
	logic [7:0]  shift_reg, tx_reg;
	logic        rw_reg, ara_reg, nack_reg;
	wire addr_hit_w = shift_reg[7:1] == slave_addr_reg; // RULE_22
	wire ara_hit_w  = (shift_reg[7:1] == `TASR_ARA_ADDR) && shift_reg[0] && alert_latch_reg;
	wire byte_w     = bit_cnt_reg == `TASR_BITS_BYTE;
	wire [7:0] tx_load_w = ara_hit_w ? {slave_addr_reg, 1'b0} : rem_temp_reg;

	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i || stop_w) // RULE_19
		begin
			state_reg <= ST_IDLE;
			serial_data_pin_oe_n_o <= 1'b1;
			bit_cnt_reg <= 4'h0;
			ara_done_reg <= 1'b0;
			ara_reg <= 1'b0;
		end
		else if (start_w) // RULE_18
		begin
			state_reg <= ST_ADDR;
			serial_data_pin_oe_n_o <= 1'b1;
			bit_cnt_reg <= 4'h0;
			ara_done_reg <= 1'b0;
			ara_reg <= 1'b0;
		end
		else
		begin
			ara_done_reg <= 1'b0;
			if (scl_rise_w)
			begin
				shift_reg <= {shift_reg[6:0], sda_w}; // RULE_17
				bit_cnt_reg <= bit_cnt_reg + 4'h1;
				if (state_reg == ST_RACK)
					nack_reg <= sda_w; // RULE_21
			end
			if (scl_fall_w)
			begin
				case (state_reg)
					ST_ADDR:
						if (byte_w)
						begin
							if (addr_hit_w || ara_hit_w)
							begin
								state_reg <= ST_AACK;
								serial_data_pin_oe_n_o <= 1'b0; // RULE_21 RULE_22
								rw_reg <= shift_reg[0];
								ara_reg <= ara_hit_w; // RULE_03
								tx_reg <= tx_load_w;
							end
							else
								state_reg <= ST_IDLE;
						end
					ST_AACK, ST_WACK:
					begin
						bit_cnt_reg <= 4'h0;
						if (rw_reg)
						begin
							state_reg <= ST_RD;
							serial_data_pin_oe_n_o <= tx_reg[7]; // RULE_17
						end
						else
						begin
							state_reg <= ST_WR;
							serial_data_pin_oe_n_o <= 1'b1;
						end
					end
					ST_WR:
						if (byte_w)
						begin
							state_reg <= ST_WACK;
							serial_data_pin_oe_n_o <= 1'b0; // RULE_21
						end
					ST_RD:
						if (byte_w)
						begin
							state_reg <= ST_RACK;
							serial_data_pin_oe_n_o <= 1'b1;
						end
						else
							serial_data_pin_oe_n_o <= tx_reg[3'h7 - bit_cnt_reg[2:0]];
					ST_RACK:
					begin
						bit_cnt_reg <= 4'h0;
						ara_done_reg <= ara_reg; // RULE_03
						ara_reg <= 1'b0;
						if (nack_reg || ara_reg)
							state_reg <= ST_IDLE;
						else
						begin
							state_reg <= ST_RD;
							serial_data_pin_oe_n_o <= tx_reg[7];
						end
					end
					ST_IDLE: state_reg <= ST_IDLE;
					default: state_reg <= ST_IDLE;
				endcase
			end
		end
	end
	always_ff @(posedge clk_sys_i)
		serial_data_pin_o <= 1'b0;

	////////////////////////////////////////////////////////////////////
	// Register reads, answer one cycle later
	logic [7:0] rd_mux_w;
	always_comb
	begin
		case (reg_addr_i)
			`TASR_OFF_CONFIG:   rd_mux_w = cfg_reg;
			`TASR_OFF_LOC_TEMP: rd_mux_w = loc_temp_reg;
			`TASR_OFF_REM_TEMP: rd_mux_w = rem_temp_reg;
			`TASR_OFF_LOC_HLIM: rd_mux_w = lim_reg.loc_hi;
			`TASR_OFF_LOC_LLIM: rd_mux_w = lim_reg.loc_lo;
			`TASR_OFF_REM_HLIM: rd_mux_w = lim_reg.rem_hi;
			`TASR_OFF_REM_LLIM: rd_mux_w = lim_reg.rem_lo;
			`TASR_OFF_STATUS:   rd_mux_w = {alert_latch_reg, comp_w, rem_open_reg,
				run_w, standby_pin_n_w, alert_mode_w, oneshot_reg, 1'b0};
			default:            rd_mux_w = 8'h00;
		endcase
	end
	always_ff @(posedge clk_sys_i)
	begin
		if (!reset_n_i)
			reg_rdata_o <= 8'h00;
		else if (reg_rd_i)
			reg_rdata_o <= rd_mux_w; // RULE_12
		else
			reg_rdata_o <= 8'h00;
	end

	////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge clk_sys_i); endclocking
	default disable iff (!reset_n_i);

	alert_set_a: assert property (alert_set_w |=> alert_latch_reg) // RULE_01
		else $error("alert not latched");
	mask_pin_a: assert property (mask_w && $past(mask_w) |-> alert_pin_oe_n_o) // RULE_02
		else $error("masked pin driven");
	ara_clear_a: assert property (ara_done_reg && !alert_set_w |=> !alert_latch_reg) // RULE_03
		else $error("response did not clear");
	rearm_now_a: assert property (ara_done_reg && alert_set_w |=> alert_latch_reg) // RULE_04
		else $error("alert not re-asserted");
	comp_follow_a: assert property (!alert_mode_w && !mask_w && comp_w |=> !alert_pin_oe_n_o) // RULE_06
		else $error("comparator not driven");
	comp_release_a: assert property (!alert_mode_w && !comp_w |=> alert_pin_oe_n_o) // RULE_07
		else $error("comparator held");
	standby_pin_a: assert property (!standby_pin_n_w |=> !conv_active_o) // RULE_10
		else $error("converting in standby");
	freeze_temp_a: assert property (!run_w |=> $stable(loc_temp_reg) && $stable(rem_temp_reg)) // RULE_11
		else $error("temperature moved in standby");
	addr_hold_a: assert property (strap_done_reg |=> $stable(slave_addr_reg)) // RULE_15
		else $error("slave address changed");
	ack_match_a: assert property (state_reg == ST_ADDR && scl_fall_w && byte_w
		&& !addr_hit_w && !ara_hit_w && !start_w && !stop_w |=> state_reg == ST_IDLE) // RULE_22
		else $error("ack on foreign address");

	ara_seen_c: cover property (ara_done_reg);
	oneshot_c: cover property (oneshot_reg ##[1:1000] !oneshot_reg);
	read_byte_c: cover property (state_reg == ST_RACK);
	comp_drive_c: cover property (!alert_mode_w && !alert_pin_oe_n_o);
endmodule

/* File: verification/tasr_host.sv */
// Host controller model: start, stop, byte write and byte read.
// Assumes the bench resolves the pulled-up open-drain data line.
`timescale 1ns/1ps
module tasr_host
(
	// Clock
	input  wire logic clk_sys_i,
	// Serial wire
	input  wire logic sda_i,
	output logic      scl_o,
	output logic      sda_o
);
	int lo_ext = 0;
	initial
	begin
		scl_o = 1'b1;
		sda_o = 1'b1;
	end
	////////////////////////
	task automatic tk(input int n);
		repeat (n) @(posedge clk_sys_i);
	endtask
	task automatic start();
		tk(2);
		sda_o <= 1'b1;
		tk(2);
		scl_o <= 1'b1;
		tk(4);
		sda_o <= 1'b0;
		tk(4);
		scl_o <= 1'b0;
	endtask
	task automatic stop();
		tk(2);
		sda_o <= 1'b0;
		tk(2);
		scl_o <= 1'b1;
		tk(4);
		sda_o <= 1'b1;
		tk(4);
	endtask
	// Low phase may be stretched to act as a slow host
	task automatic bit_io(input logic b, output logic s);
		tk(2 + lo_ext);
		sda_o <= b;
		tk(2);
		scl_o <= 1'b1;
		tk(2);
		#1 s = sda_i;
		tk(2);
		scl_o <= 1'b0;
	endtask
	task automatic wbyte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = ~s;
	endtask
	task automatic rbyte(output logic [7:0] d, input logic nack);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(nack, s);
	endtask
endmodule

/* File: verification/test_tasr_top.sv */
// Bench: register port tasks, host frames, alert pin checks.
// Assumes the host model above and a pull-up on both wires.
`timescale 1ns/1ps
`include "tasr_defines.svh"
module test_tasr_top;
	import tasr_pkg::*;
	logic       clk = 1'b0;
	logic       rst_n = 1'b0;
	logic [3:0] ra = 4'h0;
	logic [7:0] wd = 8'h00;
	logic       wr = 1'b0;
	logic       rd = 1'b0;
	logic [7:0] rdat;
	logic [7:0] lt = 8'h00;
	logic [7:0] rt = 8'h00;
	logic       ro = 1'b0;
	logic       tv = 1'b0;
	logic       conv;
	logic       standby_pin_n_n = 1'b1;
	logic       fsel = 1'b1;
	logic [1:0] shi = 2'h0;
	logic [1:0] slo = 2'h0;
	tasr_wire_t bus;
	logic       h_scl;
	logic       h_sda;
	logic       sd_o;
	logic       sd_oe_n;
	logic       al_o;
	logic       al_oe_n;
	logic [6:0] me;
	logic [7:0] d;
	logic       a;
	int         failures = 0;
	int         n_checks = 0;
	int         cyc = 0;
	assign bus = {h_scl, h_sda & (sd_oe_n | sd_o)};
	always #25 clk = ~clk;
	tasr_host host (.clk_sys_i(clk), .sda_i(bus.sda), .scl_o(h_scl), .sda_o(h_sda));
	tasr_top dut (.clk_sys_i(clk), .reset_n_i(rst_n), .reg_addr_i(ra), .reg_wdata_i(wd),
		.reg_wr_i(wr), .reg_rd_i(rd), .reg_rdata_o(rdat), .local_temp_i(lt),
		.remote_temperature_i(rt), .remote_open_i(ro), .temp_valid_i(tv),
		.conv_active_o(conv), .standby_pin_n_i(standby_pin_n_n), .pin_func_sel_i(fsel),
		.addr_strap_hi_i(shi), .addr_strap_lo_i(slo), .bus_i(bus),
		.serial_data_pin_o(sd_o), .serial_data_pin_oe_n_o(sd_oe_n),
		.alert_pin_o(al_o), .alert_pin_oe_n_o(al_oe_n));
	////////////////////////
	task automatic results();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	always @(posedge clk)
	begin
		cyc++;
		if (cyc == 20000)
		begin
			failures++;
			results();
		end
	end
	task automatic chk(input string w, input logic [7:0] e, input logic [7:0] g);
		n_checks++;
		if (g !== e)
		begin
			$display("CHECK FAILED %s expected %h seen %h", w, e, g);
			failures++;
		end
	endtask
	task automatic wt(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic wreg(input logic [3:0] ad, input logic [7:0] v);
		@(posedge clk);
		ra <= ad;
		wd <= v;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rreg(input logic [3:0] ad, input logic [7:0] e);
		@(posedge clk);
		ra <= ad;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk($sformatf("reg %h", ad), e, rdat);
	endtask
	task automatic conv_t(input logic [7:0] l, input logic [7:0] r, input logic o);
		@(posedge clk);
		lt <= l;
		rt <= r;
		ro <= o;
		tv <= 1'b1;
		@(posedge clk);
		tv <= 1'b0;
	endtask
	// Drive bit beside enable: the pin may only ever pull low
	task automatic pin(input logic e);
		wt(4);
		chk("alert pin", {6'h0, e, 1'b0}, {6'h0, al_oe_n, al_o});
	endtask
	task automatic c_conv(input logic e);
		wt(4);
		chk("conv active", {7'h0, e}, {7'h0, conv});
	endtask
	task automatic frame(input logic [6:0] ad, input logic rw, input logic e);
		host.start();
		host.wbyte({ad, rw}, a);
		chk("address ack", {7'h0, e}, {7'h0, a});
	endtask
	task automatic ara(input logic e);
		frame(`TASR_ARA_ADDR, 1'b1, e);
		if (e)
		begin
			host.rbyte(d, 1'b1);
			chk("alert response", {me, 1'b0}, d);
		end
		host.stop();
	endtask
	function automatic logic [6:0] addr_of(input int h, input int l);
		addr_of = (l == 0 ? 7'h18 : l == 1 ? 7'h29 : 7'h4c) + 7'(h);
	endfunction
	////////////////////////
	initial
	begin
		for (int l = 0; l < 3; l++)
			for (int h = 0; h < 3; h++)
			begin
				@(posedge clk);
				rst_n <= 1'b0;
				shi <= 2'(h);
				slo <= 2'(l);
				wt(8);
				@(posedge clk) rst_n <= 1'b1;
				wt(4);
				me = addr_of(h, l);
				frame(me, 1'b0, 1'b1);
				host.stop();
			end
		@(posedge clk);
		shi <= 2'h0;
		slo <= 2'h0;
		frame(me, 1'b0, 1'b1);
		host.stop();
		frame(me ^ 7'h01, 1'b0, 1'b0);
		host.stop();
		rreg(`TASR_OFF_CONFIG, `TASR_CFG_RESET);
		rreg(`TASR_OFF_REM_HLIM, `TASR_HLIM_RESET);
		rreg(`TASR_OFF_LOC_LLIM, `TASR_LLIM_RESET);
		rreg(4'h9, 8'h00);
		c_conv(1'b1);
		conv_t(8'h19, 8'h20, 1'b0);
		rreg(`TASR_OFF_REM_TEMP, 8'h20);
		frame(me, 1'b1, 1'b1);
		host.rbyte(d, 1'b1);
		chk("serial byte", 8'h20, d);
		host.stop();
		host.lo_ext = 6;
		frame(me, 1'b0, 1'b1);
		host.wbyte(8'ha5, a);
		chk("write ack", 8'h01, {7'h0, a});
		host.stop();
		host.lo_ext = 0;
		@(posedge clk) standby_pin_n_n <= 1'b0;
		c_conv(1'b0);
		conv_t(8'h30, 8'h31, 1'b0);
		wreg(`TASR_OFF_ONESHOT, 8'h01);
		c_conv(1'b0);
		rreg(`TASR_OFF_LOC_TEMP, 8'h19);
		wreg(`TASR_OFF_REM_HLIM, 8'h20);
		rreg(`TASR_OFF_REM_HLIM, 8'h20);
		frame(me, 1'b0, 1'b1);
		host.stop();
		@(posedge clk) standby_pin_n_n <= 1'b1;
		// Keep the mask set: remote sits at its limit here, an unmasked alert would latch
		wreg(`TASR_OFF_CONFIG, 8'hc0);
		c_conv(1'b0);
		wreg(`TASR_OFF_ONESHOT, 8'h01);
		c_conv(1'b1);
		conv_t(8'h1a, 8'h10, 1'b0);
		c_conv(1'b0);
		rreg(`TASR_OFF_LOC_TEMP, 8'h1a);
		wreg(`TASR_OFF_CONFIG, 8'h3f);
		rreg(`TASR_OFF_CONFIG, 8'h00);
		pin(1'b1);
		conv_t(8'h1a, 8'hf0, 1'b0);
		pin(1'b1);
		conv_t(8'h1a, 8'h20, 1'b0);
		pin(1'b0);
		wreg(`TASR_OFF_CONFIG, 8'h80);
		pin(1'b1);
		wreg(`TASR_OFF_CONFIG, 8'h00);
		ara(1'b1);
		pin(1'b0);
		conv_t(8'h1a, 8'h10, 1'b0);
		pin(1'b0);
		ara(1'b1);
		pin(1'b1);
		ara(1'b0);
		conv_t(8'hc8, 8'h10, 1'b0);
		pin(1'b0);
		conv_t(8'h7f, 8'h10, 1'b1);
		ara(1'b1);
		pin(1'b0);
		@(posedge clk) fsel <= 1'b0;
		conv_t(8'h7f, 8'h10, 1'b0);
		pin(1'b1);
		conv_t(8'h7f, 8'h20, 1'b0);
		pin(1'b0);
		conv_t(8'h1a, 8'h1f, 1'b0);
		pin(1'b1);
		conv_t(8'h1a, 8'h1f, 1'b1);
		pin(1'b0);
		wreg(`TASR_OFF_CONFIG, 8'h80);
		pin(1'b1);
		results();
	end
endmodule
